// ---- tsb_pkg.sv ----
// Shared constants and types for the segmented transmit user bus
package tsb_pkg;

  localparam int SEG_COUNT      = 4;
  localparam int PAYLOAD_W      = 128;
  localparam int CHAN_W         = 11;
  localparam int EMPTY_W        = 4;
  localparam int RANGE_W        = 2;
  localparam int FILL_W         = 6;
  localparam int FILL_DEPTH     = 32;
  localparam int FILL_THRESHOLD = 24;
  localparam int DRAIN_PER_CYC  = 2;
  localparam int CHAN_SHIFT_MIN = 8;
  localparam logic [EMPTY_W-1:0] EMPTY_ERR_MASK = 4'h8;

  typedef struct packed {
    logic [PAYLOAD_W-1:0] word;
    logic [CHAN_W-1:0]    chan;
    logic [EMPTY_W-1:0]   empty;
    logic                 first;
    logic                 last;
    logic                 bad;
  } tsb_seg_t;

  // Channel ceiling: 256, 512, 1024 or 2048 channels
  function automatic logic [CHAN_W:0] tsb_chan_limit(input logic [RANGE_W-1:0] cfg);
    tsb_chan_limit = (CHAN_W+1)'(1) << (CHAN_SHIFT_MIN + int'(cfg));
  endfunction : tsb_chan_limit

endpackage : tsb_pkg

// ---- tsb_bus_if.sv ----
// Interface joining packet source and transmit core over four segments
`timescale 1ns/100ps
interface tsb_bus_if
  import tsb_pkg::*;
(
  input wire logic clk
);
  logic [PAYLOAD_W-1:0] segment_payload_word   [SEG_COUNT];
  logic [CHAN_W-1:0]    segment_channel_number [SEG_COUNT];
  logic [EMPTY_W-1:0]   segment_empty_bytes    [SEG_COUNT];
  logic [SEG_COUNT-1:0] segment_transfer_valid;
  logic [SEG_COUNT-1:0] segment_packet_first;
  logic [SEG_COUNT-1:0] segment_packet_last;
  logic [SEG_COUNT-1:0] segment_packet_bad;
  logic                 transmit_accept_ready;
  logic                 transmit_buffer_overrun;

  modport core
  (
    input  segment_payload_word, segment_channel_number, segment_empty_bytes,
    input  segment_transfer_valid, segment_packet_first, segment_packet_last,
    input  segment_packet_bad,
    output transmit_accept_ready, transmit_buffer_overrun
  );

  modport source
  (
    output segment_payload_word, segment_channel_number, segment_empty_bytes,
    output segment_transfer_valid, segment_packet_first, segment_packet_last,
    output segment_packet_bad,
    input  transmit_accept_ready, transmit_buffer_overrun
  );
endinterface : tsb_bus_if

// ---- tsb_core_end.sv ----
// Transmit core end: samples segments, tracks fill, flags overrun
//
// How it works
// R1: Four segments, each with full qualifier set
// R2: Segment inputs ignored while its valid low
// R3: Source presents packet channel on every transfer
// R4: Channel captured whenever segment valid high
// R5: Channel range config caps usable channels
// R6: First flag only on packet's first transfer
// R7: Last flag only on packet's last transfer
// R8: Bad flag marks errored packet's final transfer
// R9: Bad flag read only with valid and last
// R10: Ready from fill threshold; source stops when low
// R11: Overrun flags transfer made against low ready
// R12: Empty byte count sampled with valid and last
// R13: Single-transfer packet sets first and last together
// R14: Channel constant across one packet's transfers
`timescale 1ns/100ps
module tsb_core_end
  import tsb_pkg::*;
#(
  parameter int FILL_LIMIT = FILL_THRESHOLD,
  parameter int DRAIN      = DRAIN_PER_CYC
)
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  tsb_bus_if.core                bus,
  input  wire logic [RANGE_W-1:0] channel_range_config,
  output logic      [SEG_COUNT-1:0] seg_taken,
  output tsb_seg_t              seg_captured [SEG_COUNT],
  output logic      [SEG_COUNT-1:0] chan_out_of_range,
  output logic      [FILL_W-1:0]  fill_level
);

  // ----------------------------------------
  // Segment capture
  // ----------------------------------------
  logic [SEG_COUNT-1:0] seg_taken_r;
  logic [SEG_COUNT-1:0] range_err_r;
  tsb_seg_t             seg_r [SEG_COUNT];
  logic [CHAN_W:0]      chan_limit;

  assign chan_limit = tsb_chan_limit(channel_range_config);

  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g++)
    begin : g_seg
      // Strobe that this segment delivered a beat last cycle
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          seg_taken_r[g] <= 1'b0;
        end
        else
        begin
          seg_taken_r[g] <= bus.segment_transfer_valid[g]; // R1
        end
      end

      // Beat capture; a segment with valid low keeps its last beat
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          seg_r[g] <= '0;
        end
        else if (bus.segment_transfer_valid[g]) // R2
        begin
          seg_r[g].word  <= bus.segment_payload_word[g];
          seg_r[g].chan  <= bus.segment_channel_number[g]; // R4
          seg_r[g].first <= bus.segment_packet_first[g];
          seg_r[g].last  <= bus.segment_packet_last[g];
          // Bad and empty mean nothing off the last transfer
          seg_r[g].bad   <= bus.segment_packet_last[g] & bus.segment_packet_bad[g]; // R9
          if (!bus.segment_packet_last[g])
          begin
            seg_r[g].empty <= '0;
          end
          else if (bus.segment_packet_bad[g])
          begin
            seg_r[g].empty <= bus.segment_empty_bytes[g] & EMPTY_ERR_MASK; // R12
          end
          else
          begin
            seg_r[g].empty <= bus.segment_empty_bytes[g]; // R12
          end
        end
      end

      // Channel ceiling check, raised only on a taken beat
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          range_err_r[g] <= 1'b0;
        end
        else if (bus.segment_transfer_valid[g])
        begin
          range_err_r[g] <= {1'b0, bus.segment_channel_number[g]} >= chan_limit; // R5
        end
        else
        begin
          range_err_r[g] <= 1'b0;
        end
      end

      assign seg_captured[g] = seg_r[g];
    end
  endgenerate

  // ----------------------------------------
  // Fill model
  // ----------------------------------------
  // Fill stands in for the downstream buffer; it drains at a fixed rate
  localparam int CNT_W = $clog2(SEG_COUNT + 1);

  logic [FILL_W-1:0] fill_r;
  logic [FILL_W-1:0] fill_nxt;
  logic [CNT_W-1:0]  n_valid;
  logic [FILL_W:0]   sum;

  always_comb
  begin
    n_valid = '0;
    for (int i = 0; i < SEG_COUNT; i++)
    begin
      n_valid = n_valid + CNT_W'(bus.segment_transfer_valid[i]);
    end
    // Saturate at the depth; beats beyond it are dropped from the count, and overrun is judged from ready alone
    sum = {1'b0, fill_r} + (FILL_W+1)'(n_valid);
    if (sum > (FILL_W+1)'(FILL_DEPTH))
    begin
      sum = (FILL_W+1)'(FILL_DEPTH);
    end
    if (sum > (FILL_W+1)'(DRAIN))
    begin
      fill_nxt = FILL_W'(sum - (FILL_W+1)'(DRAIN));
    end
    else
    begin
      fill_nxt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fill_r <= '0;
    end
    else
    begin
      fill_r <= fill_nxt;
    end
  end

  // ----------------------------------------
  // Ready and overrun
  // ----------------------------------------
  logic ready_r;
  logic ready_seen_r;
  logic ovf_r;

  // Ready drops while the buffer still has room for one beat in flight
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ready_r <= 1'b0;
    end
    else
    begin
      ready_r <= fill_nxt < FILL_W'(FILL_LIMIT); // R10
    end
  end

  // The core registers ready and the source its segment drive, so a beat sent on ready high lands a cycle
  // later; each beat is judged against ready as its source saw it
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ready_seen_r <= 1'b0;
    end
    else
    begin
      ready_seen_r <= ready_r; // R10
    end
  end

  // Sticky until reset: the source has ignored back-pressure
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ovf_r <= 1'b0;
    end
    else if (!ready_seen_r && (|bus.segment_transfer_valid))
    begin
      ovf_r <= 1'b1; // R11
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign seg_taken                   = seg_taken_r;
  assign chan_out_of_range           = range_err_r;
  assign bus.transmit_accept_ready   = ready_r;
  assign bus.transmit_buffer_overrun = ovf_r;
  assign fill_level                  = fill_r;

endmodule : tsb_core_end

// ---- tsb_source_end.sv ----
// Packet source end: splits user packets into segment transfers
`timescale 1ns/100ps
module tsb_source_end
  import tsb_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  tsb_bus_if.source                 bus,
  input  wire logic                 pkt_start,
  input  wire logic [CHAN_W-1:0]    pkt_chan,
  input  wire logic [7:0]           pkt_beats,
  input  wire logic [EMPTY_W-1:0]   pkt_empty,
  input  wire logic                 pkt_bad,
  input  wire logic [PAYLOAD_W-1:0] pkt_word,
  output logic                      pkt_busy,
  output logic                      pkt_word_req
);

  // ----------------------------------------
  // Packet sequencer, one beat per cycle on segment 0
  // ----------------------------------------
  typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_SEND = 1'b1} tsb_src_st_t;

  localparam logic [7:0] BEAT_ONE = 8'h01;

  tsb_src_st_t          st_r;
  logic [7:0]           left_r;
  logic                 first_r;
  logic [CHAN_W-1:0]    chan_r;
  logic [EMPTY_W-1:0]   empty_r;
  logic                 bad_r;
  logic                 go;
  logic                 is_last;
  logic                 v_r;
  logic                 f_r;
  logic                 l_r;
  logic                 b_r;
  logic [EMPTY_W-1:0]   e_r;
  logic [CHAN_W-1:0]    c_r;
  logic [PAYLOAD_W-1:0] w_r;

  assign go      = (st_r == ST_SEND) && bus.transmit_accept_ready; // R10
  assign is_last = (left_r == BEAT_ONE);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r    <= ST_IDLE;
      left_r  <= '0;
      first_r <= 1'b0;
      chan_r  <= '0;
      empty_r <= '0;
      bad_r   <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
          if (pkt_start && pkt_beats != '0)
          begin
            st_r    <= ST_SEND;
            left_r  <= pkt_beats;
            first_r <= 1'b1;
            chan_r  <= pkt_chan; // R14
            empty_r <= pkt_empty;
            bad_r   <= pkt_bad;
          end
        ST_SEND:
          if (go)
          begin
            first_r <= 1'b0;
            left_r  <= left_r - BEAT_ONE;
            if (is_last)
              st_r <= ST_IDLE;
          end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Registered segment drive
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      v_r <= 1'b0;
      f_r <= 1'b0;
      l_r <= 1'b0;
      b_r <= 1'b0;
      e_r <= '0;
      c_r <= '0;
      w_r <= '0;
    end
    else
    begin
      v_r <= go;
      f_r <= go & first_r; // R6 R13
      l_r <= go & is_last; // R7 R13
      b_r <= go & is_last & bad_r; // R8
      e_r <= (go && is_last) ? empty_r : '0; // R12
      c_r <= chan_r; // R3 R14
      w_r <= pkt_word;
    end
  end

  // Unused segments stay idle; this source serialises on segment 0
  always_comb
  begin
    for (int i = 0; i < SEG_COUNT; i++)
    begin
      bus.segment_transfer_valid[i] = 1'b0;
      bus.segment_packet_first[i]   = 1'b0;
      bus.segment_packet_last[i]    = 1'b0;
      bus.segment_packet_bad[i]     = 1'b0;
      bus.segment_empty_bytes[i]    = '0;
      bus.segment_channel_number[i] = '0;
      bus.segment_payload_word[i]   = '0;
    end
    bus.segment_transfer_valid[0] = v_r;
    bus.segment_packet_first[0]   = f_r;
    bus.segment_packet_last[0]    = l_r;
    bus.segment_packet_bad[0]     = b_r;
    bus.segment_empty_bytes[0]    = e_r;
    bus.segment_channel_number[0] = c_r;
    bus.segment_payload_word[0]   = w_r;
  end

  assign pkt_busy     = (st_r == ST_SEND);
  assign pkt_word_req = go;

endmodule : tsb_source_end

// ---- tsb_bus_props.sv ----
// Concurrent checks on the bus between packet source and core
`timescale 1ns/100ps
module tsb_bus_props
  import tsb_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic [SEG_COUNT-1:0] segment_transfer_valid,
  input wire logic [SEG_COUNT-1:0] segment_packet_first,
  input wire logic [SEG_COUNT-1:0] segment_packet_last,
  input wire logic [SEG_COUNT-1:0] segment_packet_bad,
  input wire logic [CHAN_W-1:0]    segment_channel_number [SEG_COUNT],
  input wire logic                 transmit_accept_ready,
  input wire logic                 transmit_buffer_overrun
);
  // ----------
  // Segment 0 framing and handshake
  // ----------
  // Source drives segment 0 only, so framing is watched there
  wire logic v0 = segment_transfer_valid[0];
  wire logic f0 = segment_packet_first[0];
  wire logic l0 = segment_packet_last[0];
  wire logic b0 = segment_packet_bad[0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> !transmit_accept_ready)
    else $error("ready high after reset");
  chk_ready_rise: assert property ($fell(sys_rst) |-> ##[1:2] transmit_accept_ready)
    else $error("ready late after reset");
  chk_no_overrun: assert property (!transmit_buffer_overrun)
    else $error("overrun while source obeyed ready");
  chk_send_ready: assert property (|segment_transfer_valid |-> $past(transmit_accept_ready))
    else $error("transfer while ready low");
  chk_bad_at_end: assert property (v0 && b0 |-> l0)
    else $error("bad flag before last");
  chk_one_first: assert property (v0 && f0 && !l0 |=> !(v0 && f0))
    else $error("second first flag in packet");
  chk_last_closes: assert property (v0 && l0 |=> !v0 || f0)
    else $error("transfer after last is no start");
  chk_chan_hold: assert property (v0 && !f0 && $past(v0) |-> $stable(segment_channel_number[0]))
    else $error("channel changed in packet");
endmodule : tsb_bus_props

// ---- tb_top.sv ----
// Bench: source joined to core, plus a second core driven by the bench
`timescale 1ns/100ps
module tb_top
  import tsb_pkg::*;
;
  logic                 clk, sys_rst, pkt_start, pkt_bad, pkt_busy, pkt_word_req;
  logic [RANGE_W-1:0]   cfg;
  logic [CHAN_W-1:0]    pkt_chan;
  logic [7:0]           pkt_beats;
  logic [EMPTY_W-1:0]   pkt_empty;
  logic [PAYLOAD_W-1:0] pkt_word;
  logic [SEG_COUNT-1:0] taken_b, oor_b;
  logic [FILL_W-1:0]    fill_b;
  tsb_seg_t             cap_a [SEG_COUNT];
  tsb_seg_t             cap_b [SEG_COUNT];
  int                   errors = 0;
  int                   compares = 0;
  tsb_bus_if bus_a (.clk(clk));
  tsb_bus_if bus_b (.clk(clk));
  tsb_source_end u_tsb_source_end (.clk(clk), .sys_rst(sys_rst), .bus(bus_a),
    .pkt_start(pkt_start), .pkt_chan(pkt_chan), .pkt_beats(pkt_beats), .pkt_empty(pkt_empty),
    .pkt_bad(pkt_bad), .pkt_word(pkt_word), .pkt_busy(pkt_busy), .pkt_word_req(pkt_word_req));
  tsb_core_end u_tsb_core_end (.clk(clk), .sys_rst(sys_rst), .bus(bus_a),
    .channel_range_config(cfg), .seg_taken(), .seg_captured(cap_a),
    .chan_out_of_range(), .fill_level());
  // Bench-driven core so that ready can be broken on purpose
  tsb_core_end u_tsb_core_end_b (.clk(clk), .sys_rst(sys_rst), .bus(bus_b),
    .channel_range_config(cfg), .seg_taken(taken_b), .seg_captured(cap_b),
    .chan_out_of_range(oor_b), .fill_level(fill_b));
  tsb_bus_props u_tsb_bus_props (.clk(clk), .sys_rst(sys_rst),
    .segment_transfer_valid(bus_a.segment_transfer_valid),
    .segment_packet_first(bus_a.segment_packet_first),
    .segment_packet_last(bus_a.segment_packet_last),
    .segment_packet_bad(bus_a.segment_packet_bad),
    .segment_channel_number(bus_a.segment_channel_number),
    .transmit_accept_ready(bus_a.transmit_accept_ready),
    .transmit_buffer_overrun(bus_a.transmit_buffer_overrun));
  // ----------
  // Helpers
  // ----------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic bound(input int k);
    if (k >= 64)
    begin
      errors++;
      finish_test();
    end
  endtask : bound
  // ----------
  // Scenarios
  // ----------
  task automatic send_pkt(input logic [10:0] ch, input logic [7:0] n, input logic [3:0] e,
                          input logic b);
    int k;
    int reqs = 0;
    {pkt_chan, pkt_beats, pkt_empty, pkt_bad} = {ch, n, e, b};
    pkt_word  = {ch, 117'h1_2345};
    pkt_start = 1'b1;
    tick();
    pkt_start = 1'b0;
    for (k = 0; k < 64 && pkt_busy !== 1'b0; k++)
    begin
      reqs += int'(pkt_word_req === 1'b1);
      tick();
    end
    bound(k);
    check("word_req", reqs, n);
    tick();
    tick();
    check("chan", cap_a[0].chan, ch);
    check("word", cap_a[0].word, {ch, 117'h1_2345});
    check("first", cap_a[0].first, n == 8'h01);
    check("last", cap_a[0].last, 1'b1);
    check("bad", cap_a[0].bad, b);
    check("empty", cap_a[0].empty, b ? {e[3], 3'h0} : e);
  endtask : send_pkt
  // Flags are {valid, first, last, bad}
  task automatic beat_b(input int s, input logic [3:0] flg, input logic [10:0] ch,
                        input logic [3:0] e);
    bus_b.segment_packet_first[s]   = flg[2];
    bus_b.segment_packet_last[s]    = flg[1];
    bus_b.segment_packet_bad[s]     = flg[0];
    bus_b.segment_channel_number[s] = ch;
    bus_b.segment_empty_bytes[s]    = e;
    // Valid is written once per beat and left up, so it never pulses in one step
    bus_b.segment_transfer_valid    = SEG_COUNT'(flg[3]) << s;
    tick();
  endtask : beat_b
  task automatic test_sampling;
    for (int s = 0; s < SEG_COUNT; s++)
    begin
      beat_b(s, 4'hC, 11'h010 + 11'(s), 4'h5);
      check("taken", taken_b[s], 1'b1);
      check("empty_mid", cap_b[s].empty, 4'h0);
      beat_b(s, 4'h7, 11'h3FF, 4'h9);
      check("idle_taken", taken_b[s], 1'b0);
      check("idle_chan", cap_b[s].chan, 11'h010 + 11'(s));
      beat_b(s, 4'h9, 11'h020, 4'h1);
      check("bad_mid", cap_b[s].bad, 1'b0);
      beat_b(s, 4'hB, 11'h020, 4'hD);
      check("bad_end", cap_b[s].bad, 1'b1);
      check("empty_bad", cap_b[s].empty, 4'h8);
    end
  endtask : test_sampling
  task automatic test_range;
    logic [11:0] lim;
    for (int c = 0; c < 4; c++)
    begin
      cfg = 2'(c);
      lim = 12'h100 << c;
      beat_b(0, 4'hE, 11'(lim - 12'h001), 4'h0);
      check("oor_below", oor_b[0], 1'b0);
      beat_b(0, 4'hE, lim[10:0], 4'h0);
      check("oor_at", oor_b[0], c < 3);
    end
  endtask : test_range
  task automatic test_backpressure;
    int k;
    bus_b.segment_transfer_valid = 4'hF;
    for (k = 0; k < 64 && bus_b.transmit_accept_ready === 1'b1; k++)
      tick();
    bound(k);
    check("fill_stop", fill_b, 6'(FILL_THRESHOLD));
    check("no_ovf", bus_b.transmit_buffer_overrun, 1'b0);
    // The beat right after ready falls is still in flight
    tick();
    check("slack_ovf", bus_b.transmit_buffer_overrun, 1'b0);
    // Valid held on one cycle more: a deliberate overrun
    tick();
    bus_b.segment_transfer_valid = 4'h0;
    check("ovf", bus_b.transmit_buffer_overrun, 1'b1);
    repeat (12) tick();
    check("ovf_held", bus_b.transmit_buffer_overrun, 1'b1);
    check("ready_back", bus_b.transmit_accept_ready, 1'b1);
  endtask : test_backpressure
  initial
  begin
    sys_rst = 1'b1;
    {cfg, pkt_start, pkt_chan, pkt_beats, pkt_empty, pkt_bad, pkt_word} = '0;
    {bus_b.segment_transfer_valid, bus_b.segment_packet_first} = '0;
    {bus_b.segment_packet_last, bus_b.segment_packet_bad} = '0;
    bus_b.segment_payload_word   = '{default: '0};
    bus_b.segment_channel_number = '{default: '0};
    bus_b.segment_empty_bytes    = '{default: '0};
    repeat (6) tick();
    sys_rst = 1'b0;
    repeat (2) tick();
    check("ready_up", bus_b.transmit_accept_ready, 1'b1);
    send_pkt(11'h005, 8'h01, 4'h3, 1'b0);
    send_pkt(11'h0A0, 8'h03, 4'hF, 1'b1);
    send_pkt(11'h0FF, 8'h02, 4'h6, 1'b0);
    test_sampling();
    test_range();
    test_backpressure();
    finish_test();
  end
endmodule : tb_top
